//--- src/exr_pkg.sv
package exr_pkg;

   // Fixed upper bits of the target address; low two bits come from pins
   localparam logic [4:0] ADDR_FIXED  = 5'h1d;
   localparam int         NUM_REGS    = 8;
   localparam logic [2:0] PTR_RESET   = 3'h0;
   localparam logic [3:0] BITS_BYTE   = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;
   // Reset contents of the writable registers 2..7
   localparam logic [7:0] RST_OUTPUT  = 8'hff;
   localparam logic [7:0] RST_POLAR   = 8'h00;
   localparam logic [7:0] RST_CONFIG  = 8'hff;
   // Time of one link clock period in the bench
   localparam int         LINK_PERIOD_NS = 125;
   localparam int         CLOCK_MHZ      = 200;
   localparam int         LINK_CYCLES    = LINK_PERIOD_NS * CLOCK_MHZ / 1000;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_RX    = 5'h02,
      ST_RXACK = 5'h04,
      ST_TX    = 5'h08,
      ST_TXACK = 5'h10
   } exr_state_t;

   typedef enum logic [1:0] {
      KIND_ADDR = 2'h0,
      KIND_CMD  = 2'h1,
      KIND_DATA = 2'h2
   } exr_kind_t;

   typedef struct packed {
      logic       scl_s1;
      logic       scl_s2;
      logic       scl_d;
      logic       sda_s1;
      logic       sda_s2;
      logic       sda_d;
      logic [1:0] asel_s1;
      logic [1:0] asel_s2;
      logic [15:0] pin_s1;
      logic [15:0] pin_s2;
   } exr_sync_t;

   typedef struct packed {
      exr_sync_t  sy;
      exr_state_t state;
      exr_kind_t  kind;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic       rw;
      logic       master_ack;
      logic       drive;
      logic [2:0] ptr;
      logic [15:0] snap;
   } exr_core_t;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] mem;
      logic [7:0]               rdata;
   } exr_mem_t;

endpackage : exr_pkg

//--- src/exr_regmem.sv
`timescale 1ns/1ps
module exr_regmem (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       clk_en,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // Read port, one cycle latency
   input  wire logic [2:0] rd_addr,
   output logic      [7:0] rd_data
);

   exr_pkg::exr_mem_t m_reg;
   exr_pkg::exr_mem_t m_next;

   always_comb begin
      m_next       = m_reg;
      m_next.rdata = m_reg.mem[rd_addr];
      if (wr_en) begin
         m_next.mem[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         m_reg.mem   <= {exr_pkg::RST_CONFIG, exr_pkg::RST_CONFIG,
                         exr_pkg::RST_POLAR,  exr_pkg::RST_POLAR,
                         exr_pkg::RST_OUTPUT, exr_pkg::RST_OUTPUT,
                         8'h00, 8'h00};
         m_reg.rdata <= 8'h00;
      end else if (clk_en) begin
         m_reg <= m_next;
      end
   end

   assign rd_data = m_reg.rdata;

endmodule : exr_regmem

//--- src/exr_target.sv
`timescale 1ns/1ps
module exr_target (
   // Clock, reset, enable
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   // Serial link pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n,
   // Address select pins
   input  wire logic        addr_select_low_pin,
   input  wire logic        addr_select_high_pin,
   // Input port pins
   input  wire logic [15:0] port_in
);

   exr_pkg::exr_core_t st_reg;
   exr_pkg::exr_core_t st_next;

   logic       ev_rise;
   logic       ev_fall;
   logic       ev_start;
   logic       ev_stop;
   logic       wr_en;
   logic [2:0] rd_addr;
   logic [7:0] rd_data;

   function automatic logic [7:0] sel_byte(input logic [2:0]  p,
                                           input logic [15:0] snap,
                                           input logic [7:0]  rdata);
      if (p == 3'h0) begin
         sel_byte = snap[7:0];
      end else if (p == 3'h1) begin
         sel_byte = snap[15:8];
      end else begin
         sel_byte = rdata;
      end
   endfunction : sel_byte

   function automatic logic own_addr(input logic [6:0] a,
                                     input logic [1:0] pins);
      own_addr = (a == {exr_pkg::ADDR_FIXED, pins});
   endfunction : own_addr

   ////////////////////////////////////////////////////////////////////////
   // Link events from synchronised samples
   assign ev_rise  = clk_en & st_reg.sy.scl_s2 & ~st_reg.sy.scl_d;
   assign ev_fall  = clk_en & ~st_reg.sy.scl_s2 & st_reg.sy.scl_d;
   assign ev_start = clk_en & st_reg.sy.scl_s2 & st_reg.sy.scl_d &
                     ~st_reg.sy.sda_s2 & st_reg.sy.sda_d;
   assign ev_stop  = clk_en & st_reg.sy.scl_s2 & st_reg.sy.scl_d &
                     st_reg.sy.sda_s2 & ~st_reg.sy.sda_d;

   // Next register comes from the pair partner once the ack is in
   assign rd_addr = (st_reg.state == exr_pkg::ST_TXACK) ?
                    (st_reg.ptr ^ 3'h1) : st_reg.ptr;

   // Input port registers are read only
   assign wr_en = clk_en & ev_rise & (st_reg.state == exr_pkg::ST_RXACK) &
                  (st_reg.kind == exr_pkg::KIND_DATA) &
                  (st_reg.ptr[2:1] != 2'h0);

   exr_regmem u_mem (
      .clock   (clock),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .wr_en   (wr_en),
      .wr_addr (st_reg.ptr),
      .wr_data (st_reg.shift),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Protocol engine
   always_comb begin
      logic [7:0] nb;
      nb = 8'h00;
      st_next = st_reg;
      st_next.sy.scl_s1  = scl_i;
      st_next.sy.scl_s2  = st_reg.sy.scl_s1;
      st_next.sy.scl_d   = st_reg.sy.scl_s2;
      st_next.sy.sda_s1  = sda_i;
      st_next.sy.sda_s2  = st_reg.sy.sda_s1;
      st_next.sy.sda_d   = st_reg.sy.sda_s2;
      st_next.sy.asel_s1 = {addr_select_high_pin, addr_select_low_pin};
      st_next.sy.asel_s2 = st_reg.sy.asel_s1;
      st_next.sy.pin_s1  = port_in;
      st_next.sy.pin_s2  = st_reg.sy.pin_s1;

      if (ev_stop) begin
         // Pointer and stored data left as they are
         st_next.state = exr_pkg::ST_IDLE;
         st_next.drive = 1'b0;
      end else if (ev_start) begin
         // Restart keeps the pointer on the register being accessed
         st_next.state   = exr_pkg::ST_RX;
         st_next.kind    = exr_pkg::KIND_ADDR;
         st_next.bit_cnt = 4'h0;
         st_next.drive   = 1'b0;
      end else begin
         unique case (st_reg.state)
            exr_pkg::ST_IDLE: begin
            end
            exr_pkg::ST_RX: begin
               if (ev_rise) begin
                  st_next.shift   = {st_reg.shift[6:0], st_reg.sy.sda_s2};
                  st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               end else if (ev_fall && st_reg.bit_cnt == exr_pkg::BITS_BYTE) begin
                  st_next.state = exr_pkg::ST_RXACK;
                  st_next.drive = 1'b1;
                  if (st_reg.kind == exr_pkg::KIND_ADDR) begin
                     st_next.rw = st_reg.shift[0];
                     if (!own_addr(st_reg.shift[7:1], st_reg.sy.asel_s2)) begin
                        st_next.state = exr_pkg::ST_IDLE;
                        st_next.drive = 1'b0;
                     end
                  end else if (st_reg.kind == exr_pkg::KIND_CMD) begin
                     st_next.ptr = st_reg.shift[2:0];
                  end
               end
            end
            exr_pkg::ST_RXACK: begin
               if (ev_rise) begin
                  // Input pins sampled at the ack clock edge
                  st_next.snap = st_reg.sy.pin_s2;
                  if (st_reg.kind == exr_pkg::KIND_DATA) begin
                     st_next.ptr = st_reg.ptr ^ 3'h1;
                  end
               end else if (ev_fall) begin
                  st_next.bit_cnt = 4'h0;
                  if (st_reg.kind == exr_pkg::KIND_ADDR && st_reg.rw) begin
                     nb = sel_byte(st_reg.ptr, st_reg.snap, rd_data);
                     st_next.state = exr_pkg::ST_TX;
                     st_next.shift = nb;
                     st_next.drive = ~nb[7];
                  end else begin
                     st_next.state = exr_pkg::ST_RX;
                     st_next.drive = 1'b0;
                     st_next.kind  = (st_reg.kind == exr_pkg::KIND_ADDR) ?
                                     exr_pkg::KIND_CMD : exr_pkg::KIND_DATA;
                  end
               end
            end
            exr_pkg::ST_TX: begin
               if (ev_fall) begin
                  if (st_reg.bit_cnt == exr_pkg::LAST_TX_BIT) begin
                     st_next.state   = exr_pkg::ST_TXACK;
                     st_next.drive   = 1'b0;
                     st_next.bit_cnt = 4'h0;
                  end else begin
                     st_next.shift   = {st_reg.shift[6:0], 1'b0};
                     st_next.drive   = ~st_reg.shift[6];
                     st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                  end
               end
            end
            exr_pkg::ST_TXACK: begin
               if (ev_rise) begin
                  st_next.master_ack = ~st_reg.sy.sda_s2;
                  st_next.snap       = st_reg.sy.pin_s2;
               end else if (ev_fall) begin
                  if (st_reg.master_ack) begin
                     // Keeps going for as long as the controller acks
                     nb = sel_byte(st_reg.ptr ^ 3'h1, st_reg.snap, rd_data);
                     st_next.ptr   = st_reg.ptr ^ 3'h1;
                     st_next.state = exr_pkg::ST_TX;
                     st_next.shift = nb;
                     st_next.drive = ~nb[7];
                  end else begin
                     // Not acked: wait for stop or restart, SDA released
                     st_next.state = exr_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_reg         <= '0;
         st_reg.sy      <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                             sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                             default: '0};
         st_reg.state   <= exr_pkg::ST_IDLE;
         st_reg.kind    <= exr_pkg::KIND_ADDR;
         st_reg.ptr     <= exr_pkg::PTR_RESET;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // Open-drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_n = ~st_reg.drive;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_addr_ack;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_RX && st_reg.kind == exr_pkg::KIND_ADDR &&
       ev_fall && st_reg.bit_cnt == exr_pkg::BITS_BYTE &&
       st_reg.shift[7:1] == {exr_pkg::ADDR_FIXED, st_reg.sy.asel_s2})
      |=> st_reg.drive && st_reg.state == exr_pkg::ST_RXACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("own address not acknowledged");

   property p_tx_first;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_RXACK && ev_fall && st_reg.rw &&
       st_reg.kind == exr_pkg::KIND_ADDR)
      |=> st_reg.state == exr_pkg::ST_TX && st_reg.drive == ~st_reg.shift[7];
   endproperty
   a_tx_first: assert property (p_tx_first)
      else $error("read address not followed by transmit");

   property p_more;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_TXACK && st_reg.master_ack && ev_fall)
      |=> st_reg.state == exr_pkg::ST_TX;
   endproperty
   a_more: assert property (p_more)
      else $error("acknowledged read did not continue");

   property p_alternate;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_TXACK && st_reg.master_ack && ev_fall)
      |=> st_reg.ptr == ($past(st_reg.ptr) ^ 3'h1);
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("pointer did not move to pair partner");

   property p_restart;
      @(posedge clock) disable iff (!resetn)
      (ev_start && !ev_stop) |=> st_reg.ptr == $past(st_reg.ptr) &&
                                 st_reg.state == exr_pkg::ST_RX;
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart disturbed the pointer");

   property p_capture;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_TXACK && ev_rise && !ev_stop)
      |=> st_reg.snap == $past(st_reg.sy.pin_s2);
   endproperty
   a_capture: assert property (p_capture)
      else $error("pins not captured at ack edge");

   property p_stop;
      @(posedge clock) disable iff (!resetn)
      ev_stop |=> st_reg.state == exr_pkg::ST_IDLE && !st_reg.drive &&
                  $stable(st_reg.ptr);
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop not honoured");

   property p_input_sel;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_RXACK && ev_fall && st_reg.rw &&
       st_reg.kind == exr_pkg::KIND_ADDR && st_reg.ptr == 3'h0)
      |=> st_reg.shift == st_reg.snap[7:0];
   endproperty
   a_input_sel: assert property (p_input_sel)
      else $error("command zero did not return input pins");

   property p_keep_ptr;
      @(posedge clock) disable iff (!resetn)
      (st_reg.state == exr_pkg::ST_IDLE) |=> $stable(st_reg.ptr);
   endproperty
   a_keep_ptr: assert property (p_keep_ptr)
      else $error("pointer changed between transactions");

endmodule : exr_target

//--- sim/exr_ctl_model.sv
`timescale 1ns/1ps
module exr_ctl_model (
   // Clock
   input  wire logic clock,
   // Wire levels
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_low
);
   // Link clock rests high between frames
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   // Setup 6 clocks, sample mid high phase, 25 clocks a bit
   task automatic bit_io(input logic b, output logic r);
      sda_low <= ~b;
      tick(6);
      scl <= 1'b1;
      tick(6);
      r = sda_in;
      tick(6);
      scl <= 1'b0;
      tick(7);
   endtask : bit_io
   task automatic start_c();
      if (!scl) begin
         sda_low <= 1'b0;
         tick(6);
         scl <= 1'b1;
         tick(6);
      end
      sda_low <= 1'b1;
      tick(6);
      scl <= 1'b0;
      tick(6);
   endtask : start_c
   task automatic stop_c();
      sda_low <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(6);
      sda_low <= 1'b0;
      tick(12);
   endtask : stop_c
   // Short nbits leaves the byte unfinished
   task automatic xfer(input logic [7:0] d, input int nbits, input logic b9,
                       output logic [7:0] q, output logic r9);
      logic r;
      q  = 8'h00;
      r9 = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         bit_io(d[7-i], r);
         q = {q[6:0], r};
      end
      if (nbits == 8) bit_io(b9, r9);
   endtask : xfer
endmodule : exr_ctl_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic        clock;
   logic        resetn;
   logic [1:0]  asel;
   logic [15:0] port_in;
   logic        sda_o;
   logic        sda_oe_n;
   logic        scl;
   logic        sda_low;
   wire logic   sda_w = ~((~sda_oe_n & ~sda_o) | sda_low);
   int          miscompares;
   int          n_tests;
   logic [7:0]  mem [8];
   int          ptr;
   logic [7:0]  q;
   logic        ak;

   exr_target dut (
      .clock                (clock),
      .resetn               (resetn),
      .clk_en               (1'b1),
      .scl_i                (scl),
      .sda_i                (sda_w),
      .sda_o                (sda_o),
      .sda_oe_n             (sda_oe_n),
      .addr_select_low_pin  (asel[0]),
      .addr_select_high_pin (asel[1]),
      .port_in              (port_in)
   );
   exr_ctl_model ctl (
      .clock   (clock),
      .sda_in  (sda_w),
      .scl     (scl),
      .sda_low (sda_low)
   );

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [7:0] expect_byte(input int p);
      if (p == 0) return port_in[7:0];
      if (p == 1) return port_in[15:8];
      return mem[p];
   endfunction : expect_byte
   task automatic addr(input logic rw, input logic good);
      logic [7:0] a;
      a = {exr_pkg::ADDR_FIXED, asel, rw};
      if (!good) a = a ^ 8'h04;
      ctl.xfer(a, 8, 1'b1, q, ak);
      chk({7'h0, ak}, {7'h0, ~good});
   endtask : addr
   // Write phase: address, command, n data bytes, no stop
   task automatic wr(input logic [2:0] c, input int n);
      logic [7:0] d;
      ctl.start_c();
      addr(1'b0, 1'b1);
      ctl.xfer({5'h00, c}, 8, 1'b1, q, ak);
      chk({7'h0, ak}, 8'h00);
      ptr = c;
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         ctl.xfer(d, 8, 1'b1, q, ak);
         chk({7'h0, ak}, 8'h00);
         if (ptr > 1) mem[ptr] = d;
         ptr = ptr ^ 1;
      end
   endtask : wr
   // Read n bytes with restart or start, last one not acknowledged
   task automatic rd(input int n);
      ctl.start_c();
      addr(1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         if (i > 0) ptr = ptr ^ 1;
         ctl.xfer(8'hff, 8, i == n - 1, q, ak);
         chk(q, expect_byte(ptr));
      end
   endtask : rd
   task automatic new_pins();
      @(posedge clock);
      asel    <= 2'($urandom);
      port_in <= 16'($urandom);
      ctl.tick(6);
   endtask : new_pins

   ////////////////////////////////////////////////////////////////////////
   initial begin
      resetn      = 1'b0;
      asel        = 2'h0;
      port_in     = 16'h0000;
      miscompares = 0;
      n_tests     = 0;
      mem         = '{8'h00, 8'h00,
                      exr_pkg::RST_OUTPUT, exr_pkg::RST_OUTPUT,
                      exr_pkg::RST_POLAR, exr_pkg::RST_POLAR,
                      exr_pkg::RST_CONFIG, exr_pkg::RST_CONFIG};
      ptr         = 0;
      void'($urandom(24515));
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      new_pins();
      // Foreign address is left unanswered
      ctl.start_c();
      addr(1'b0, 1'b0);
      ctl.stop_c();
      wr(3'h4, 2);
      ctl.stop_c();
      wr(3'h2, 1);
      ctl.stop_c();
      // Every register, two bytes each; odd ones get a write first,
      // which input register 1 must ignore
      for (int c = 0; c < 8; c++) begin
         new_pins();
         wr(3'(c), c & 1);
         rd(2);
         ctl.stop_c();
      end
      // Long read, then restart resumes on the last register
      new_pins();
      wr(3'h1, 0);
      rd(5);
      rd(2);
      ctl.stop_c();
      new_pins();
      rd(1);
      ctl.stop_c();
      // Byte cut short by a stop leaves the register alone
      wr(3'h6, 0);
      ctl.xfer(8'h3c, 3, 1'b1, q, ak);
      ctl.stop_c();
      rd(1);
      ctl.stop_c();
      summarize();
   end

   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      summarize();
   end
endmodule : tb
